// File: rtl/srap_pkg.sv
// package: constants and state types of the serial register access port
`default_nettype none
package srap_pkg;
    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int ADDR_W = 5;
    localparam int REG_W = 5;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 32;
    localparam logic [4:0] CNT_HDR_LAST = 5'h07;  // rise count before the 8th header bit
    localparam logic [4:0] CNT_RD_LAUNCH = 5'h08; // fall after 8 rises drives D0
    localparam logic [4:0] CNT_RD_END = 5'h0d;    // fall after 13 rises ends a read
    localparam logic [4:0] CNT_WR_LAST = 5'h0f;   // rise count before the 16th bit
    localparam logic [4:0] CNT_WR_END = 5'h10;    // rises seen when a write is over
    localparam logic [4:0] CNT_ADDR_FIRST = 5'h01;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h05;
    localparam logic [4:0] REG_RESET = 5'h00;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_SYS_NS = 5;
    localparam int LINK_PERIOD_NS = 64;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_SYS_NS);
    // ************************************************************
    // state types
    // ************************************************************
    typedef enum logic [2:0] {
        DEV_IDLE = 3'h0,
        DEV_HDR = 3'h1,
        DEV_RDAT = 3'h3,
        DEV_WDAT = 3'h5,
        DEV_DONE = 3'h7
    } srap_dev_state_t;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'h0,
        HOST_WAIT = 2'h1,
        HOST_RUN = 2'h3,
        HOST_END = 2'h2
    } srap_host_state_t;
endpackage
`default_nettype wire

// File: rtl/srap_if.sv
// interface: the four serial wires between host and device
`default_nettype none
interface srap_if;
    logic sclk;
    logic csN;
    logic serialInLine;
    logic serialInOe;
    logic serialOutLine;
    logic serialOutOe;
    modport dev (
        input sclk,
        input csN,
        input serialInLine,
        output serialOutLine,
        output serialOutOe
    );
    modport host (
        output sclk,
        output csN,
        output serialInLine,
        output serialInOe,
        input serialOutLine
    );
endinterface
`default_nettype wire

// File: rtl/srap_device.sv
// device end: serial slave holding the command registers
`default_nettype none
module srap_device #(
    parameter int NUM_REGS = srap_pkg::NUM_REGS,
    parameter logic [4:0] RESET_VAL = srap_pkg::REG_RESET
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    srap_if.dev link,
    output logic [NUM_REGS*srap_pkg::REG_W-1:0] cmdRegs,
    output logic wrStrobe,
    output logic [srap_pkg::ADDR_W-1:0] wrAddr
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] sclkSync;
    logic [1:0] csSync;
    logic [1:0] sdiSync;
    logic sclkPrev;

    // two flops per pin, then one more for edge finding
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclkSync <= 2'h0;
            csSync <= 2'h3;
            sdiSync <= 2'h0;
            sclkPrev <= 1'b0;
        end else begin
            sclkSync <= {sclkSync[0], link.sclk};
            csSync <= {csSync[0], link.csN};
            sdiSync <= {sdiSync[0], link.serialInLine};
            sclkPrev <= sclkSync[1];
        end
    end

    // ************************************************************
    // edge and frame decode
    // ************************************************************
    wire sclkRise = sclkSync[1] & ~sclkPrev;
    wire sclkFall = ~sclkSync[1] & sclkPrev;
    wire selActive = ~csSync[1];
    wire sdiBit = sdiSync[1];

    srap_pkg::srap_dev_state_t state;
    srap_pkg::srap_dev_state_t next_state;
    logic [4:0] bitCnt;
    logic dirRead;
    logic [srap_pkg::ADDR_W-1:0] addr;
    logic [srap_pkg::DATA_W-1:0] wrShift;
    logic [srap_pkg::REG_W-1:0] rdShift;
    logic outLine;
    logic outOe;
    logic [srap_pkg::REG_W-1:0] regFile [NUM_REGS];

    wire [srap_pkg::DATA_W-1:0] next_wrShift = {sdiBit, wrShift[srap_pkg::DATA_W-1:1]};
    wire [srap_pkg::REG_W-1:0] selReg = regFile[addr];
    wire inAddr = (bitCnt >= srap_pkg::CNT_ADDR_FIRST) && (bitCnt <= srap_pkg::CNT_ADDR_LAST);
    wire hdrEnd = sclkRise && (bitCnt == srap_pkg::CNT_HDR_LAST);
    wire rdLaunch = sclkFall && (bitCnt == srap_pkg::CNT_RD_LAUNCH);
    wire rdEnd = sclkFall && (bitCnt == srap_pkg::CNT_RD_END);
    wire wrLast = sclkRise && (bitCnt == srap_pkg::CNT_WR_LAST) && (state == srap_pkg::DEV_WDAT);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            srap_pkg::DEV_IDLE: begin
                if (selActive) begin
                    next_state = srap_pkg::DEV_HDR;
                end
            end
            srap_pkg::DEV_HDR: begin
                // idle bits end the header either way
                if (hdrEnd) begin
                    next_state = dirRead ? srap_pkg::DEV_RDAT : srap_pkg::DEV_WDAT;
                end
            end
            srap_pkg::DEV_RDAT: begin
                if (rdEnd) begin
                    next_state = srap_pkg::DEV_DONE;
                end
            end
            srap_pkg::DEV_WDAT: begin
                if (wrLast) begin
                    next_state = srap_pkg::DEV_DONE;
                end
            end
            srap_pkg::DEV_DONE: begin
                next_state = srap_pkg::DEV_DONE;
            end
            default: begin
                next_state = srap_pkg::DEV_IDLE;
            end
        endcase
        if (!selActive) begin
            next_state = srap_pkg::DEV_IDLE;
        end
    end

    // ************************************************************
    // header capture and bit counting
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= srap_pkg::DEV_IDLE;
            bitCnt <= 5'h00;
            dirRead <= 1'b0;
            addr <= '0;
            wrShift <= '0;
        end else begin
            state <= next_state;
            if (!selActive) begin
                bitCnt <= 5'h00;
            end else if (sclkRise && state != srap_pkg::DEV_DONE) begin
                // every frame bit on a rise, none once done
                bitCnt <= bitCnt + 5'h01;
                // first bit selects read or write
                if (bitCnt == 5'h00) begin
                    dirRead <= sdiBit;
                end
                if (inAddr) begin
                    addr <= {sdiBit, addr[srap_pkg::ADDR_W-1:1]};
                end
                // eighth header bit is not stored
                // write data waits out idle bits
                // write data on rises, LSB first
                if (state == srap_pkg::DEV_WDAT) begin
                    wrShift <= next_wrShift;
                end
            end
        end
    end

    // ************************************************************
    // read data return
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            outLine <= 1'b0;
            outOe <= 1'b0;
            rdShift <= '0;
        end else if (!selActive) begin
            outOe <= 1'b0;
            outLine <= 1'b0;
        end else if (state == srap_pkg::DEV_RDAT) begin
            // driver on at the eighth fall
            if (rdLaunch) begin
                outOe <= 1'b1;
                outLine <= selReg[0];
                rdShift <= selReg >> 1;
            end else if (rdEnd) begin
                // float once D4 has been held
                outOe <= 1'b0;
                outLine <= 1'b0;
            end else if (sclkFall && outOe) begin
                outLine <= rdShift[0];
                rdShift <= rdShift >> 1;
            end
        end
    end

    // ************************************************************
    // command registers
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : gen_reg
            localparam int IDX = gi;
            // keep only the low five data bits
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    regFile[gi] <= RESET_VAL;
                end else if (wrLast && addr == IDX[srap_pkg::ADDR_W-1:0]) begin
                    regFile[gi] <= next_wrShift[srap_pkg::REG_W-1:0];
                end
            end
            assign cmdRegs[gi*srap_pkg::REG_W +: srap_pkg::REG_W] = regFile[gi];
        end
    endgenerate

    // write notice to the user side
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrStrobe <= 1'b0;
            wrAddr <= '0;
        end else begin
            wrStrobe <= wrLast;
            if (wrLast) begin
                wrAddr <= addr;
            end
        end
    end

    assign link.serialOutLine = outLine;
    assign link.serialOutOe = outOe;
endmodule
`default_nettype wire

// File: rtl/srap_host.sv
// host end: issues read and write frames on the serial port
`default_nettype none
module srap_host #(
    parameter int HALF_CYC = srap_pkg::LINK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    srap_if.host link,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqRead,
    input wire logic [srap_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [srap_pkg::DATA_W-1:0] reqData,
    output logic doneValid,
    output logic [srap_pkg::REG_W-1:0] doneData
);
    // ************************************************************
    // clock divider
    // ************************************************************
    logic [7:0] divCnt;
    logic sclk;
    wire divWrap = (divCnt == 8'(HALF_CYC - 1));
    wire riseNow = divWrap & ~sclk;
    wire fallNow = divWrap & sclk;

    // clock runs free, before and between frames
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divCnt <= 8'h00;
            sclk <= 1'b0;
        end else begin
            divCnt <= divWrap ? 8'h00 : divCnt + 8'h01;
            if (divWrap) begin
                sclk <= ~sclk;
            end
        end
    end

    // ************************************************************
    // read line synchroniser
    // ************************************************************
    logic [1:0] sdoSync;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sdoSync <= 2'h0;
        end else begin
            sdoSync <= {sdoSync[0], link.serialOutLine};
        end
    end

    // ************************************************************
    // frame sequencer
    // ************************************************************
    srap_pkg::srap_host_state_t state;
    logic [4:0] cnt;
    logic isRead;
    logic [15:0] txShift;
    logic [srap_pkg::REG_W-1:0] rxShift;
    logic csN;
    logic serial_in_line;
    logic sdiOe;
    wire [4:0] endCnt = isRead ? srap_pkg::CNT_RD_END : srap_pkg::CNT_WR_END;
    wire rdSample = isRead && cnt >= srap_pkg::CNT_RD_LAUNCH && cnt < srap_pkg::CNT_RD_END;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= srap_pkg::HOST_IDLE;
            reqReady <= 1'b1;
            doneValid <= 1'b0;
            doneData <= '0;
            cnt <= 5'h00;
            isRead <= 1'b0;
            txShift <= 16'h0000;
            rxShift <= '0;
            csN <= 1'b1;
            serial_in_line <= 1'b0;
            sdiOe <= 1'b0;
        end else begin
            doneValid <= 1'b0;
            unique case (state)
                srap_pkg::HOST_IDLE: begin
                    if (reqValid) begin
                        // fixed zero bit, ignored bit zero too
                        txShift <= {reqData, 2'b00, reqAddr, reqRead};
                        isRead <= reqRead;
                        reqReady <= 1'b0;
                        state <= srap_pkg::HOST_WAIT;
                    end
                end
                srap_pkg::HOST_WAIT: begin
                    // select drops half a period before the first rise
                    if (fallNow) begin
                        csN <= 1'b0;
                        serial_in_line <= txShift[0];
                        sdiOe <= 1'b1;
                        cnt <= 5'h00;
                        state <= srap_pkg::HOST_RUN;
                    end
                end
                srap_pkg::HOST_RUN: begin
                    if (riseNow) begin
                        cnt <= cnt + 5'h01;
                        // read bit taken on the rise after its launch
                        if (rdSample) begin
                            rxShift <= {sdoSync[1], rxShift[srap_pkg::REG_W-1:1]};
                        end
                    end else if (fallNow) begin
                        if (cnt == endCnt) begin
                            csN <= 1'b1;
                            sdiOe <= 1'b0;
                            state <= srap_pkg::HOST_END;
                        end else begin
                            // next bit set up a half period ahead
                            serial_in_line <= txShift[1];
                            txShift <= txShift >> 1;
                            // hand the shared wire over only after the eighth header bit
                            if (isRead && cnt == srap_pkg::CNT_RD_LAUNCH) begin
                                sdiOe <= 1'b0;
                            end
                        end
                    end
                end
                srap_pkg::HOST_END: begin
                    doneValid <= 1'b1;
                    doneData <= isRead ? rxShift : '0;
                    reqReady <= 1'b1;
                    state <= srap_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    assign link.sclk = sclk;
    assign link.csN = csN;
    assign link.serialInLine = serial_in_line;
    assign link.serialInOe = sdiOe;
endmodule
`default_nettype wire

// File: sim/srap_sva.sv
// checker: frame timing on the serial wires between host and device
`default_nettype none
module srap_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic serialInLine,
    input wire logic serialInOe,
    input wire logic serialOutLine,
    input wire logic serialOutOe
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // frame tracking
    // ************************************************************
    logic sclkQ;
    logic dirRd;
    logic [4:0] riseCnt;
    wire sclkRise = sclk && !sclkQ;
    wire [4:0] next_riseCnt = csN ? 5'h00 : riseCnt + {4'h0, sclkRise};
    wire next_dirRd = (sclkRise && !csN && riseCnt == 5'h00) ? serialInLine : dirRd;
    // rises seen in this frame and its direction
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclkQ <= 1'b0;
            riseCnt <= 5'h00;
            dirRd <= 1'b0;
        end else begin
            sclkQ <= sclk;
            riseCnt <= next_riseCnt;
            dirRd <= next_dirRd;
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    AST_SEL_BEFORE_RISE: assert property ($fell(csN) |-> !sclk [*5])
        else $error("select dropped too close to a rising clock edge");
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*5])
        else $error("serial clock high phase too short");
    AST_FIXED_ZERO: assert property (sclkRise && !csN && riseCnt == 5'h06 |-> !serialInLine)
        else $error("seventh header bit not zero");
    AST_FRAME_LEN: assert property ($rose(csN) |-> riseCnt == (dirRd ? 5'h0d : 5'h10))
        else $error("frame length wrong for its direction");
    AST_HOST_DRIVES: assert property (!csN && sclk && (riseCnt < 5'h08 || !dirRd) |-> serialInOe)
        else $error("host not driving header or write data");
    AST_OE_LAUNCH: assert property ($rose(serialOutOe) |-> dirRd && riseCnt == 5'h08 && !sclk)
        else $error("read driver enabled at wrong moment");
    AST_OE_READ_ONLY: assert property (serialOutOe |-> dirRd)
        else $error("output driven outside a read");
    AST_NO_FIGHT: assert property (!(serialOutOe && serialInOe))
        else $error("both ends drive the shared wire");
    AST_DESELECT_FLOAT: assert property (csN [*5] |-> !serialOutOe)
        else $error("output still driven after deselect");
    AST_RD_HOLD: assert property (sclk && $past(sclk) && serialOutOe |-> $stable(serialOutLine))
        else $error("read data moved while clock high");
    // main scenarios
    cover property ($rose(serialOutOe));
    cover property ($rose(csN) && dirRd);
    cover property ($rose(csN) && !dirRd);
endmodule
`default_nettype wire

// File: sim/testbench.sv
// testbench: host and device back to back, plus a bench-driven device
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0;
    logic reqRead = 1'b0;
    logic [4:0] reqAddr = 5'h00;
    logic [7:0] reqData = 8'h00;
    logic reqReady;
    logic doneValid;
    logic [4:0] doneData;
    logic [159:0] cmdRegs;
    logic [159:0] cmdRegsB;
    logic wrStrobe;
    logic [4:0] wrAddr;
    logic [4:0] mirror [32];
    logic [4:0] expRd [$];
    logic [9:0] expWr [$];
    logic [31:0] seed = 32'hdf3e;
    logic [15:0] got;
    int failures = 0;
    int num_checks = 0;
    srap_if linkA();
    srap_if linkB();
    srap_host u_srap_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(linkA), .reqValid(reqValid),
        .reqReady(reqReady), .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData),
        .doneValid(doneValid), .doneData(doneData));
    srap_device u_srap_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(linkA),
        .cmdRegs(cmdRegs), .wrStrobe(wrStrobe), .wrAddr(wrAddr));
    srap_device u_srap_device_b (.clk_sys(clk_sys), .rst_n(rst_n), .link(linkB),
        .cmdRegs(cmdRegsB), .wrStrobe(), .wrAddr());
    srap_sva u_srap_sva (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(linkA.sclk), .csN(linkA.csN),
        .serialInLine(linkA.serialInLine), .serialInOe(linkA.serialInOe),
        .serialOutLine(linkA.serialOutLine), .serialOutOe(linkA.serialOutOe));
    // ************************************************************
    // helpers
    // ************************************************************
    always #2.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one request to the host end, expectations noted
    task automatic hostOp(input logic rd, input logic [4:0] a, input logic [7:0] d);
        int n;
        @(negedge clk_sys);
        for (n = 0; reqReady !== 1'b1 && n < 5000; n++) @(negedge clk_sys);
        // host never came back: count it and close the run
        if (n >= 5000) begin
            failures++;
            wrap_up();
        end
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqRead <= rd;
        reqAddr <= a;
        reqData <= d;
        expRd.push_back(rd ? mirror[a] : 5'h00);
        if (!rd) begin
            mirror[a] = d[4:0];
            expWr.push_back({a, d[4:0]});
        end
        @(posedge clk_sys);
        reqValid <= 1'b0;
    endtask
    // header lsb first: direction, address, zero, ignored bit set
    function automatic logic [15:0] frm(input logic rd, input logic [4:0] a, input logic [7:0] d);
        return {d, 1'b1, 1'b0, a, rd};
    endfunction
    // bench as host on the second link, 64 ns clock off the system grid
    task automatic bang(input logic [15:0] b, input int n, output logic [15:0] res);
        res = 16'h0000;
        @(posedge clk_sys);
        #0.3;
        linkB.csN = 1'b0;
        for (int i = 0; i < n; i++) begin
            linkB.serialInLine = b[i];
            #32;
            res[i] = linkB.serialOutLine;
            linkB.sclk = 1'b1;
            #32;
            linkB.sclk = 1'b0;
        end
        #32;
        linkB.csN = 1'b1;
        linkB.serialInLine = ~b[n-1];
        #64;
    endtask
    // ************************************************************
    // scoreboard
    // ************************************************************
    always @(negedge clk_sys) begin
        if (doneValid === 1'b1) begin
            check(doneData, expRd.pop_front());
        end
        if (wrStrobe === 1'b1) begin
            check({wrAddr, cmdRegs[int'(wrAddr)*5 +: 5]}, expWr.pop_front());
        end
    end
    // watchdog
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int n;
        logic [4:0] a;
        logic [7:0] d;
        linkB.csN = 1'b1;
        linkB.sclk = 1'b0;
        linkB.serialInLine = 1'b0;
        linkB.serialInOe = 1'b1;
        for (int i = 0; i < 32; i++) mirror[i] = srap_pkg::REG_RESET;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset value of every register, reads back to back
        for (int i = 0; i < 32; i++) hostOp(1'b1, i[4:0], 8'h00);
        // random mix of reads and writes
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            hostOp(seed[0], seed[5:1], seed[13:6]);
        end
        for (n = 0; (reqReady !== 1'b1 || expRd.size() != 0) && n < 5000; n++) @(negedge clk_sys);
        if (n >= 5000) begin
            failures++;
            wrap_up();
        end
        check(16'(expRd.size()), 16'h0000);
        check(16'(expWr.size()), 16'h0000);
        // ignored bit set, aborted write, fresh read
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            a = seed[4:0];
            d = seed[12:5];
            bang(frm(1'b0, a, d), 16, got);
            check(cmdRegsB[int'(a)*5 +: 5], d[4:0]);
            bang(frm(1'b0, a, ~d), 12, got);
            check(cmdRegsB[int'(a)*5 +: 5], d[4:0]);
            bang(frm(1'b1, a, seed[20:13]), 13, got);
            check(got[12:8], d[4:0]);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
